// File: ican_pkg.sv
// package: register map, field positions and constants of the abort/nack/setup block
package ican_pkg;
	localparam logic [7:0]  ICAN_OFF_ABORT_CAUSE = 8'h80;
	localparam logic [7:0]  ICAN_OFF_NACK_CTRL   = 8'h84;
	localparam logic [7:0]  ICAN_OFF_SDA_SETUP   = 8'h94;
	localparam logic [7:0]  ICAN_OFF_CORE_CTRL   = 8'hA0;
	localparam logic [7:0]  ICAN_OFF_CORE_EVENT  = 8'hA4;
	localparam logic [7:0]  ICAN_OFF_ABORT_CLR   = 8'hA8;
	localparam int          ICAN_BIT_ENABLE      = 0;
	localparam int          ICAN_BIT_RESTART     = 5;
	localparam int          ICAN_BIT_SLV_ACTIVE  = 6;
	localparam int          ICAN_ABORT_BITS      = 10;
	localparam int          ICAN_FLUSH_LSB       = 23;
	localparam int          ICAN_FLUSH_W         = 9;
	localparam logic [7:0]  ICAN_SETUP_RESET     = 8'h00;
	localparam logic        ICAN_NACK_RESET      = 1'b0;
	localparam logic [1:0]  ICAN_RESP_OKAY       = 2'b00;
	localparam logic [1:0]  ICAN_RESP_SLVERR     = 2'b10;
	localparam int          ICAN_SETUP_MIN       = 2;
	localparam int          ICAN_BIT_SBYTE_NORST = 9;
	typedef enum logic [1:0] {
		ICAN_TX_IDLE  = 2'b00,
		ICAN_TX_WAIT  = 2'b01,
		ICAN_TX_HOLD  = 2'b10
	} ican_tx_t;
endpackage

// File: ican_top.sv
// ican_top: abort cause reporting, forced slave data nack and sda setup delay
//
// Overview of operation
// - flag start byte attempted with restarts disabled
// - clearing bit 9 while cause persists re-sets it
// - flag high speed attempted with restarts disabled
// - flag acknowledged start byte
// - flag acknowledged high speed master code
// - flag read queued after general call
// - flag unacknowledged general call
// - flag unacknowledged data byte, master only
// - flag unacknowledged second wide address byte
// - flag unacknowledged first wide address byte
// - flag unacknowledged short address
// - nack control writable only disabled and idle
// - forced nack: nack, abort, discard byte
// - nack control clear: normal acknowledge criteria
// - nack control exists only when parameter one
// - slave transmit holds scl low setup periods
// - setup delay writable only while disabled
// - count flushed commands, clear when disabled
`timescale 1ns/1ps
module ican_top
	import ican_pkg::*;
#(
	parameter int FORCED_NACK_BUILD_PARAM = 1
) (
	// clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      resetn,
	// axi4-lite write address and data
	input  wire logic [7:0]                s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]                s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// core transfer engine status
	input  wire logic                      slave_active,
	input  wire logic [ICAN_ABORT_BITS-1:0] abort_cond,
	input  wire logic                      master_mode,
	input  wire logic                      cmd_flushed,
	input  wire logic                      rx_byte_done,
	input  wire logic                      rx_normal_ack,
	input  wire logic                      slv_tx_sda_change,
	// serial link
	input  wire logic                      scl_in,
	output logic                           scl_out,
	output logic                           scl_oe,
	// core controls
	output logic                           ctrl_enable,
	output logic                           restart_allow,
	output logic                           transmit_abort_event,
	output logic                           rx_nack,
	output logic                           rx_push,
	output logic                           rx_abort
);

	// build options the logic cannot serve are refused at elaboration
	if (FORCED_NACK_BUILD_PARAM != 0 && FORCED_NACK_BUILD_PARAM != 1) begin : g_bad_nack_param
		$error("forced nack build parameter must be 0 or 1");
	end
	// the read word packs the flush count into the top bits, above the causes
	if (ICAN_FLUSH_LSB + ICAN_FLUSH_W != 32 || ICAN_ABORT_BITS > ICAN_FLUSH_LSB) begin : g_bad_layout
		$error("flush count and cause bits do not fit one word");
	end
	// the cause gating below is written out per bit for ten causes
	if (ICAN_ABORT_BITS != 10) begin : g_bad_causes
		$error("cause gating expects ten abort bits");
	end

	// axi write channel capture
	// the write decodes from the held address, never from the live bus
	logic                        aw_held;
	logic                        w_held;
	logic [7:0]                  aw_addr;
	logic [31:0]                 w_data;
	logic [3:0]                  w_strb;
	wire                         wr_go = aw_held && w_held && !s_axi_bvalid;
	wire                         rd_go = s_axi_arvalid && s_axi_arready;

	wire                         hit_cause  = aw_addr == ICAN_OFF_ABORT_CAUSE;
	wire                         hit_nack   = aw_addr == ICAN_OFF_NACK_CTRL;
	wire                         hit_setup  = aw_addr == ICAN_OFF_SDA_SETUP;
	wire                         hit_ctrl   = aw_addr == ICAN_OFF_CORE_CTRL;
	wire                         hit_evt    = aw_addr == ICAN_OFF_CORE_EVENT;
	wire                         hit_clr    = aw_addr == ICAN_OFF_ABORT_CLR;
	wire                         wr_mapped  = hit_cause | hit_nack | hit_setup | hit_ctrl
	                                          | hit_evt | hit_clr;

	// registers
	// strobe bit 0 carries every writable field except the abort clear, which ignores strobes; upper strobes are ignored
	logic                        slave_data_nack_ctrl;
	logic [7:0]                  sda_setup_delay;
	logic [ICAN_ABORT_BITS-1:0]  abort_cause;
	logic [ICAN_FLUSH_W-1:0]     flushed_command_count;

	// slave activity sync of the outside-domain flag is not needed: same clock core
	// a write refused by its guard still completes with an okay response
	wire                         nack_wr_ok = wr_go && hit_nack && w_strb[0]
	                                          && !ctrl_enable && !slave_active;
	wire                         setup_wr_ok = wr_go && hit_setup && w_strb[0]
	                                           && !ctrl_enable;
	wire                         clr_wr = wr_go && hit_clr;

	// abort causes with master-only gating where the cause is master only
	// causes 9 and 8 depend on restarts being off, not on the master role
	logic [ICAN_ABORT_BITS-1:0]  cause_hit;
	assign cause_hit[9] = abort_cond[9] && !restart_allow;
	assign cause_hit[8] = abort_cond[8] && !restart_allow;
	assign cause_hit[7] = abort_cond[7] && master_mode;
	assign cause_hit[6] = abort_cond[6] && master_mode;
	assign cause_hit[5] = abort_cond[5] && master_mode;
	assign cause_hit[4] = abort_cond[4] && master_mode;
	assign cause_hit[3] = abort_cond[3] && master_mode;
	assign cause_hit[2] = abort_cond[2] && master_mode;
	assign cause_hit[1] = abort_cond[1] && master_mode;
	assign cause_hit[0] = abort_cond[0] && master_mode;

	// set wins over clear; a persisting bit 9 cause drops for one cycle only
	logic [ICAN_ABORT_BITS-1:0]  clr_mask;
	logic                        sbyte_reassert;
	assign clr_mask = clr_wr ? w_data[ICAN_ABORT_BITS-1:0] : '0;
	wire [ICAN_ABORT_BITS-1:0]   set_now = cause_hit & ~({ICAN_ABORT_BITS{1'b0}}
	                                       | (clr_mask & (10'h1 << ICAN_BIT_SBYTE_NORST)));
	wire [ICAN_ABORT_BITS-1:0]   next_abort_cause = (abort_cause & ~clr_mask) | set_now
	                                       | ({ICAN_ABORT_BITS{1'b0}}
	                                          | ({9'h000, sbyte_reassert} << ICAN_BIT_SBYTE_NORST));
	wire                         new_abort = |(set_now & ~abort_cause);

	// the one-cycle gap on bit 9 shows software that its clear did not hold
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			abort_cause    <= '0;
			sbyte_reassert <= 1'b0;
		end else begin
			abort_cause    <= next_abort_cause;
			sbyte_reassert <= clr_mask[ICAN_BIT_SBYTE_NORST] && cause_hit[9];
		end
	end

	// one pulse per cycle in which any bit newly sets; a bit already set raises nothing again
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			transmit_abort_event <= 1'b0;
		else
			transmit_abort_event <= new_abort || sbyte_reassert;
	end

	// saturates rather than wraps, so a long abort burst never reads small
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			flushed_command_count <= '0;
		else if (!ctrl_enable)
			flushed_command_count <= '0;
		else if (cmd_flushed && flushed_command_count != '1)
			flushed_command_count <= flushed_command_count + 1'b1;
	end

	// control registers
	// enable and restart are taken from one strobe so they change together
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			slave_data_nack_ctrl <= ICAN_NACK_RESET;
			sda_setup_delay      <= ICAN_SETUP_RESET;
			ctrl_enable          <= 1'b0;
			restart_allow        <= 1'b0;
		end else begin
			if (nack_wr_ok && FORCED_NACK_BUILD_PARAM == 1)
				slave_data_nack_ctrl <= w_data[0];
			if (setup_wr_ok)
				sda_setup_delay <= w_data[7:0];
			if (wr_go && hit_ctrl && w_strb[0]) begin
				ctrl_enable   <= w_data[ICAN_BIT_ENABLE];
				restart_allow <= w_data[ICAN_BIT_RESTART];
			end
		end
	end

	// slave receiver byte decision
	// a forced nack drops the byte even where the core would have acked it
	wire                         force_nack = slave_data_nack_ctrl && rx_byte_done;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rx_nack  <= 1'b0;
			rx_push  <= 1'b0;
			rx_abort <= 1'b0;
		end else begin
			rx_nack  <= force_nack || (rx_byte_done && !rx_normal_ack);
			rx_push  <= rx_byte_done && !slave_data_nack_ctrl && rx_normal_ack;
			rx_abort <= force_nack;
		end
	end

	// scl from the link is sampled three deep; change counts when stages 2 and 3 agree
	// reset to high so no false low is seen before the first samples arrive
	logic [2:0]                  scl_sync;
	logic                        scl_level;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			scl_sync  <= 3'b111;
			scl_level <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[1:0], scl_in};
			if (scl_sync[1] == scl_sync[2])
				scl_level <= scl_sync[2];
		end
	end

	// setup stretch: after sda moves, keep scl low for the programmed clk_sys periods
	// values below two give a one-cycle stretch; software must not use them
	// the count loads only in idle, so an sda change mid-stretch is not stacked
	ican_tx_t                    tx_state;
	ican_tx_t                    next_tx_state;
	logic [7:0]                  setup_cnt;
	wire                         setup_done = setup_cnt <= 8'h01;
	always_comb begin
		next_tx_state = tx_state;
		case (tx_state)
			ICAN_TX_IDLE: begin
				if (slv_tx_sda_change && ctrl_enable)
					next_tx_state = ICAN_TX_HOLD;
			end
			ICAN_TX_HOLD: begin
				if (setup_done)
					next_tx_state = ICAN_TX_WAIT;
			end
			ICAN_TX_WAIT: begin
				if (scl_level)
					next_tx_state = ICAN_TX_IDLE;
			end
			default: next_tx_state = ICAN_TX_IDLE;
		endcase
	end

	// after release, the return to idle waits for the line to read high, so a slow remote clock is not cut
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tx_state  <= ICAN_TX_IDLE;
			setup_cnt <= 8'h00;
			scl_out   <= 1'b0;
			scl_oe    <= 1'b0;
		end else begin
			tx_state <= next_tx_state;
			if (tx_state == ICAN_TX_IDLE)
				setup_cnt <= sda_setup_delay;
			else if (!setup_done)
				setup_cnt <= setup_cnt - 8'h01;
			scl_oe <= next_tx_state == ICAN_TX_HOLD;
		end
	end

	// axi slave handshakes
	// a write waits in the holding registers until the response slot is free
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= ICAN_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? ICAN_RESP_OKAY : ICAN_RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ready pulses every other cycle while its own channel holds nothing and no response waits, so a held valid is taken once only
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
		end
	end

	// read decode
	// unmapped reads answer with an error and a zero word
	logic [31:0]                 rd_word;
	logic                        rd_hit;
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		case (s_axi_araddr)
			ICAN_OFF_ABORT_CAUSE: rd_word = {flushed_command_count, 13'h0000, abort_cause};
			ICAN_OFF_NACK_CTRL:   rd_word = {31'h0000_0000, slave_data_nack_ctrl};
			ICAN_OFF_SDA_SETUP:   rd_word = {24'h00_0000, sda_setup_delay};
			ICAN_OFF_CORE_CTRL:   rd_word = {26'h000_0000, restart_allow, 4'h0, ctrl_enable};
			ICAN_OFF_CORE_EVENT:  rd_word = {25'h000_0000, slave_active, 6'h00};
			ICAN_OFF_ABORT_CLR:   rd_word = 32'h0000_0000;
			default:              rd_hit  = 1'b0;
		endcase
	end

	// the address still stands at the taking edge, so the word is decoded from it
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= ICAN_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_hit ? ICAN_RESP_OKAY : ICAN_RESP_SLVERR;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// File: ican_checker.sv
// checker: port-level relations of the abort, nack and stretch block
`timescale 1ns/1ps
module ican_checker
	import ican_pkg::*;
(
	// clock and reset
	input wire logic                       clk_sys,
	input wire logic                       resetn,
	// bus answers
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	input wire logic [1:0]                 s_axi_bresp,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready,
	input wire logic [31:0]                s_axi_rdata,
	// core side
	input wire logic [ICAN_ABORT_BITS-1:0] abort_cond,
	input wire logic                       rx_byte_done,
	input wire logic                       rx_normal_ack,
	input wire logic                       slv_tx_sda_change,
	input wire logic                       scl_out,
	input wire logic                       scl_oe,
	input wire logic                       transmit_abort_event,
	input wire logic                       rx_nack,
	input wire logic                       rx_push,
	input wire logic                       rx_abort
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_dropped;
		rx_abort && rx_nack && !rx_push;
	endsequence
	sequence s_rx_quiet;
		!rx_nack && !rx_push && !rx_abort;
	endsequence

	property p_abort_whole;
		rx_abort |-> s_dropped;
	endproperty
	a_abort_whole: assert property (p_abort_whole) else $error("abort without nack or with push");
	property p_reject_nack;
		rx_byte_done && !rx_normal_ack |=> rx_nack && !rx_push;
	endproperty
	a_reject_nack: assert property (p_reject_nack) else $error("rejected byte not nacked");
	property p_rx_cause;
		!rx_byte_done |=> s_rx_quiet;
	endproperty
	a_rx_cause: assert property (p_rx_cause) else $error("receive pulse without a byte");
	property p_byte_answer;
		rx_byte_done |=> rx_push ^ rx_nack;
	endproperty
	a_byte_answer: assert property (p_byte_answer) else $error("byte neither pushed nor nacked");
	property p_evt_cause;
		transmit_abort_event |-> $past(|abort_cond) || $past(|abort_cond, 2);
	endproperty
	a_evt_cause: assert property (p_evt_cause) else $error("abort event without cause");
	property p_evt_pulse;
		transmit_abort_event |=> !transmit_abort_event;
	endproperty
	a_evt_pulse: assert property (p_evt_pulse) else $error("abort event longer than a cycle");
	property p_stretch_cause;
		$rose(scl_oe) |-> $past(slv_tx_sda_change) || $past(slv_tx_sda_change, 2);
	endproperty
	a_stretch_cause: assert property (p_stretch_cause) else $error("scl stretched without sda change");
	property p_stretch_min;
		$rose(scl_oe) |-> scl_oe [*2];
	endproperty
	a_stretch_min: assert property (p_stretch_min) else $error("scl stretch shorter than two");
	property p_od_low;
		scl_oe |-> !scl_out;
	endproperty
	a_od_low: assert property (p_od_low) else $error("scl driven high");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
endmodule

// File: ican_far_master.sv
// remote bus master model: drives scl from the far side of the link
`timescale 1ns/1ps
module ican_far_master (
	// line from the block
	input  wire logic scl_oe,
	input  wire logic scl_out,
	// frame control and line level
	input  wire logic run,
	output logic      scl_in
);
	logic lvl;
	// wired line, pull-up keeps it high when nobody pulls
	assign scl_in = scl_oe ? scl_out : lvl;
	initial begin
		lvl = 1'b1;
		forever begin
			if (!run) begin
				lvl = 1'b1;
				wait (run);
			end
			#400 lvl = ~lvl;
			// high phase starts only once the block lets go
			if (lvl) wait (scl_in);
		end
	end
endmodule

// File: tb_top.sv
// testbench: registers, abort causes, forced nack and scl stretching
`timescale 1ns/1ps
module tb_top;
	import ican_pkg::*;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [ICAN_ABORT_BITS-1:0] abort_cond;
	logic clk_sys, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic slave_active, master_mode, cmd_flushed, rx_byte_done, rx_normal_ack, slv_tx_sda_change;
	logic scl_in, scl_out, scl_oe, ctrl_enable, restart_allow, transmit_abort_event;
	logic rx_nack, rx_push, rx_abort, mm, rs, ak, link_run;
	int n_mismatch, num_checks, seed, n, cnt;

	ican_top #(.FORCED_NACK_BUILD_PARAM(1)) i_dut (.*);
	ican_far_master i_far (.scl_oe(scl_oe), .scl_out(scl_out), .run(link_run), .scl_in(scl_in));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t word %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t resp %b want %b", $time, got, exp);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	task automatic rx_byte();
		@(posedge clk_sys) rx_byte_done <= 1'b1;
		@(posedge clk_sys) rx_byte_done <= 1'b0;
		#10;
	endtask
	function automatic logic [31:0] exp_cause(int i, logic m, logic r);
		// causes 9 and 8 need restarts off, the rest need master mode
		return ((i >= 8) ? !r : m) ? (32'h1 << i) : 32'h0;
	endfunction
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		seed = 63536;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, abort_cond} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{slave_active, master_mode, cmd_flushed, rx_byte_done, rx_normal_ack} = '0;
		{slv_tx_sda_change, link_run, resetn} = '0;
		s_axi_wstrb = 4'hF;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (2) @(posedge clk_sys);
		axr(ICAN_OFF_ABORT_CAUSE); chk_word(rd, 32'h0);
		axr(ICAN_OFF_NACK_CTRL); chk_word(rd, 32'h0);
		axr(ICAN_OFF_SDA_SETUP); chk_word(rd, 32'h0);
		axr(8'h10); chk_resp(rsp, ICAN_RESP_SLVERR);
		$display("test reset_map done");
		axw(ICAN_OFF_CORE_CTRL, 32'h1);
		chk_word({31'h0, ctrl_enable}, 32'h1);
		axw(ICAN_OFF_SDA_SETUP, 32'h5);
		axr(ICAN_OFF_SDA_SETUP); chk_word(rd, 32'h0);
		axw(ICAN_OFF_CORE_CTRL, 32'h0);
		axw(ICAN_OFF_SDA_SETUP, 32'h4);
		axr(ICAN_OFF_SDA_SETUP); chk_word(rd, 32'h4);
		slave_active <= 1'b1;
		axw(ICAN_OFF_NACK_CTRL, 32'h1);
		axr(ICAN_OFF_NACK_CTRL); chk_word(rd, 32'h0);
		slave_active <= 1'b0;
		axw(ICAN_OFF_NACK_CTRL, 32'h1);
		axr(ICAN_OFF_NACK_CTRL); chk_word(rd, 32'h1);
		$display("test write_guard done");
		for (int k = 0; k < 8; k++) begin
			if (k == 4) axw(ICAN_OFF_NACK_CTRL, 32'h0);
			ak = 1'($random(seed));
			rx_normal_ack <= ak;
			rx_byte();
			if (k < 4) chk_word({29'h0, rx_nack, rx_push, rx_abort}, 32'h5);
			else chk_word({29'h0, rx_nack, rx_push, rx_abort}, {29'h0, !ak, ak, 1'b0});
		end
		$display("test forced_nack done");
		for (int k = 0; k < 20; k++) begin
			// first pass makes every cause eligible, second is random
			mm = (k < 10) ? 1'b1 : 1'($random(seed));
			rs = (k < 10) ? 1'b0 : 1'($random(seed));
			master_mode <= mm;
			axw(ICAN_OFF_CORE_CTRL, {26'h0, rs, 5'h0});
			@(posedge clk_sys) abort_cond <= 10'h1 << (k % 10);
			repeat (2) @(posedge clk_sys);
			chk_word({31'h0, restart_allow}, {31'h0, rs});
			chk_word({31'h0, transmit_abort_event}, {31'h0, exp_cause(k % 10, mm, rs) != 32'h0});
			abort_cond <= '0;
			repeat (3) @(posedge clk_sys);
			axr(ICAN_OFF_ABORT_CAUSE);
			chk_word(rd & 32'h3FF, exp_cause(k % 10, mm, rs));
			axw(ICAN_OFF_ABORT_CLR, 32'h3FF);
			axr(ICAN_OFF_ABORT_CAUSE); chk_word(rd & 32'h3FF, 32'h0);
		end
		axw(ICAN_OFF_CORE_CTRL, 32'h0);
		@(posedge clk_sys) abort_cond <= 10'h200;
		repeat (3) @(posedge clk_sys);
		axw(ICAN_OFF_ABORT_CLR, 32'h200);
		repeat (2) @(posedge clk_sys);
		axr(ICAN_OFF_ABORT_CAUSE); chk_word(rd & 32'h3FF, 32'h200);
		abort_cond <= '0;
		axw(ICAN_OFF_ABORT_CLR, 32'h200);
		axr(ICAN_OFF_ABORT_CAUSE); chk_word(rd & 32'h3FF, 32'h0);
		$display("test abort_causes done");
		n = 1 + ($random(seed) & 7);
		axw(ICAN_OFF_CORE_CTRL, 32'h1);
		repeat (n) begin
			@(posedge clk_sys) cmd_flushed <= 1'b1;
			@(posedge clk_sys) cmd_flushed <= 1'b0;
		end
		repeat (2) @(posedge clk_sys);
		axr(ICAN_OFF_ABORT_CAUSE); chk_word(rd >> ICAN_FLUSH_LSB, 32'(n));
		axw(ICAN_OFF_CORE_CTRL, 32'h0);
		axr(ICAN_OFF_ABORT_CAUSE); chk_word(rd >> ICAN_FLUSH_LSB, 32'h0);
		$display("test flush_count done");
		axw(ICAN_OFF_CORE_CTRL, 32'h1);
		link_run <= 1'b1;
		repeat (6) @(posedge clk_sys);
		cnt = 0;
		@(posedge clk_sys) slv_tx_sda_change <= 1'b1;
		@(posedge clk_sys) slv_tx_sda_change <= 1'b0;
		repeat (30) begin
			#1 cnt += (scl_oe === 1'b1);
			@(posedge clk_sys);
		end
		chk_word(32'(cnt), 32'h4);
		link_run <= 1'b0;
		$display("test scl_stretch done");
		end_of_test();
	end

	initial begin
		#2000000;
		n_mismatch++;
		$display("BAD %0t watchdog expired", $time);
		end_of_test();
	end
endmodule

bind ican_top ican_checker i_chk (.*);
